// ==== logic/gnsshc_top.sv ====
// Purpose: Host control: I2C sentence port, power states, command set
// Assumes: Commands arrive already parsed, on the core clock
// Notes:   scl, sda and force_on are pins and are synchronised
//
// The address map and the APB slave port were decided locally.

`timescale 1ns/100ps

module gnsshc_top
    import gnsshc_pkg::*;
#(
    parameter logic [31:0] HOLD_CY = 32'(HOLD_CYC),
    parameter logic [31:0] ON_CY   = 32'(PER_ON_CY),
    parameter logic [31:0] OFF_CY  = 32'(PER_OFF_CY),
    parameter logic [31:0] PPS_CY  = 32'(PPS_P_CYC)
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // APB slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // I2C pins
    input  wire logic        scl,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    // Sentence stream into the transmit buffer
    input  wire logic        nmea_valid,
    input  wire logic [7:0]  nmea_data,
    output logic             nmea_ready,
    // Parsed commands and serial activity
    input  wire logic        cmd_valid,
    input  wire gnsshc_cmd_t cmd,
    input  wire logic        rx_byte,
    // Power hold pin
    input  wire logic        force_on,
    // Outputs
    output logic             wakeup,
    output logic             second_pulse_output,
    output logic             echo_valid,
    output gnsshc_act_t      action,
    output logic [2:0]       gnss_mask,
    output logic             sbas_en
);

    function automatic logic is_cmd(input gnsshc_cmd_t c,
                                    input logic [9:0]  id,
                                    input logic [2:0]  n);
        is_cmd = (c.id == id) && (c.nparm == n);
    endfunction

    function automatic logic [7:0] ptr_inc(input logic [7:0] p);
        ptr_inc = (p == 8'(BUF_DEPTH - 1)) ? 8'h00 : p + 8'h01;
    endfunction

    // Synchronisers and edge history
    logic scl_m_r, scl_s_r, scl_d_r;
    logic sda_m_r, sda_s_r, sda_d_r;
    logic frc_m_r, frc_s_r, frc_d_r;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            {scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
            {sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
            {frc_m_r, frc_s_r, frc_d_r} <= 3'h0;
        end else begin
            {scl_m_r, scl_s_r, scl_d_r} <= {scl, scl_m_r, scl_s_r};
            {sda_m_r, sda_s_r, sda_d_r} <= {sda_in, sda_m_r, sda_s_r};
            {frc_m_r, frc_s_r, frc_d_r} <= {force_on, frc_m_r, frc_s_r};
        end
    end

    wire scl_rise = scl_s_r & ~scl_d_r;
    wire scl_fall = ~scl_s_r & scl_d_r;
    wire i2_start = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
    wire i2_stop  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
    wire frc_rise = frc_s_r & ~frc_d_r;
    wire frc_fall = ~frc_s_r & frc_d_r;

    // Command decode
    wire [3:0] p0     = cmd.parm[0];
    wire       p0_bit = (p0 <= 4'h1);
    wire       pm_any = cmd_valid && (cmd.id == CMD_POWER_MODE)
                        && (cmd.nparm != 3'h0);
    wire       pm0    = pm_any && (cmd.nparm == 3'h1) && (p0 == PM_FULL);
    wire       pm1    = pm_any && (p0 == PM_PERIODIC);
    wire       pm4    = pm_any && (cmd.nparm == 3'h1) && (p0 == PM_BACKUP);
    wire       c_test = cmd_valid && is_cmd(cmd, CMD_LINK_TEST, 3'h0);
    wire       c_hot  = cmd_valid && is_cmd(cmd, CMD_HOT, 3'h0);
    wire       c_warm = cmd_valid && is_cmd(cmd, CMD_WARM, 3'h0);
    wire       c_cold = cmd_valid && is_cmd(cmd, CMD_COLD, 3'h0);
    wire       c_full = cmd_valid && is_cmd(cmd, CMD_FULL_RST, 3'h0);
    wire       c_eaid = cmd_valid && is_cmd(cmd, CMD_ERASE_AID, 3'h0);
    wire       c_eorb = cmd_valid && is_cmd(cmd, CMD_ERASE_ORB, 3'h0);
    wire       c_stby = cmd_valid && is_cmd(cmd, CMD_STANDBY, 3'h1)
                        && p0_bit;
    wire       c_pe   = cmd_valid && is_cmd(cmd, CMD_PULSE_EN, 3'h1)
                        && p0_bit;
    wire       c_aug  = cmd_valid && is_cmd(cmd, CMD_AUGMENT, 3'h1)
                        && p0_bit;
    wire [4:0] flg    = {cmd.parm[4][0], cmd.parm[3][0], cmd.parm[2][0],
                         cmd.parm[1][0], cmd.parm[0][0]};
    wire       flg_ok = (cmd.parm[4][3:1] == 3'h0)
                        && (cmd.parm[3][3:1] == 3'h0)
                        && (cmd.parm[2][3:1] == 3'h0)
                        && (cmd.parm[1][3:1] == 3'h0)
                        && (cmd.parm[0][3:1] == 3'h0);
    // Flags three and four name no system here, so they must be zero
    wire       c_cs   = cmd_valid && is_cmd(cmd, CMD_CONST_SEL, 3'h5)
                        && flg_ok && (flg[3:2] == 2'h0)
                        && (flg[0] | flg[1] | flg[4]);

    // Power state
    gnsshc_pw_t  pw_r, pw_nxt;
    logic [31:0] hold_r, per_r;
    logic        awake_r;
    wire         long_hold = (hold_r >= HOLD_CY);
    wire         per_end   = (per_r + 32'h1) >= (awake_r ? ON_CY : OFF_CY);

    always_comb begin
        pw_nxt = pw_r;
        case (pw_r)
            PW_FULL: begin
                if (pm4) begin
                    pw_nxt = frc_s_r ? PW_STOP : PW_BACKUP;
                end else if (pm1 && !frc_s_r) begin
                    pw_nxt = PW_PERIOD;
                end else if (c_stby) begin
                    pw_nxt = p0[0] ? PW_SLEEP : PW_STOP;
                end
            end
            PW_BACKUP: begin
                if (frc_fall && long_hold) begin
                    pw_nxt = PW_FULL;
                end
            end
            PW_PERIOD: begin
                if (pm0 && frc_s_r) begin
                    pw_nxt = PW_FULL;
                end
            end
            PW_STOP, PW_SLEEP: begin
                if (rx_byte || (frc_rise && long_hold)) begin
                    pw_nxt = PW_FULL;
                end
            end
            default: pw_nxt = PW_FULL;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pw_r    <= PW_FULL;
            hold_r  <= 32'h0;
            per_r   <= 32'h0;
            awake_r <= 1'b1;
            wakeup  <= 1'b1;
        end else begin
            pw_r    <= pw_nxt;
            hold_r  <= (frc_rise | frc_fall) ? 32'h0 :
                       long_hold ? hold_r : hold_r + 32'h1;
            per_r   <= (pw_r != PW_PERIOD || per_end) ? 32'h0 : per_r + 32'h1;
            awake_r <= (pw_r != PW_PERIOD) ? 1'b1 : awake_r ^ per_end;
            wakeup  <= (pw_r == PW_FULL)
                       || (pw_r == PW_PERIOD && awake_r);
        end
    end

    // Command effects; settings are untouched by restarts
    logic        pol_r;
    logic [31:0] ppsw_r, ppsp_r, pps_cnt_r;
    logic        pps_en_r;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            echo_valid <= 1'b0;
            action     <= '0;
            gnss_mask  <= MASK_RST;
            sbas_en    <= 1'b0;
            pps_en_r   <= 1'b0;
        end else begin
            echo_valid       <= c_test;
            action.hot       <= c_hot;
            action.warm      <= c_warm;
            action.cold      <= c_cold;
            action.full_rst  <= c_full;
            action.erase_aid <= c_eaid;
            action.erase_orb <= c_eorb;
            action.cfg_save  <= c_pe | c_aug | c_cs;
            if (c_cs) begin
                gnss_mask <= {flg[4], flg[1], flg[0]};
            end
            if (c_aug) begin
                sbas_en <= p0[0];
            end
            if (c_pe) begin
                pps_en_r <= p0[0];
            end
        end
    end

    // Second pulse; counts only at full power
    wire pps_run = pps_en_r && (pw_r == PW_FULL);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pps_cnt_r           <= 32'h0;
            second_pulse_output <= 1'b0;
        end else begin
            pps_cnt_r <= (!pps_run || (pps_cnt_r + 32'h1) >= ppsp_r) ?
                         32'h0 : pps_cnt_r + 32'h1;
            second_pulse_output <= (pps_run && pps_cnt_r < ppsw_r)
                                   ^ pol_r;
        end
    end

    // Transmit buffer
    logic [7:0] mem [0:BUF_DEPTH-1];
    logic [7:0] wr_r, rd_r, cnt_r, pk_r, pk_nxt;
    logic       pop;
    wire        push    = nmea_valid & nmea_ready;
    wire        have    = (cnt_r != 8'h0) && (pk_r < PKT_MAX);
    wire  [7:0] tx_byte = have ? mem[rd_r] : FILL_BYTE;
    wire  [7:0] cnt_nxt = cnt_r + {7'h0, push} - {7'h0, pop};

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_r] <= nmea_data;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_r       <= 8'h0;
            rd_r       <= 8'h0;
            cnt_r      <= 8'h0;
            nmea_ready <= 1'b1;
        end else begin
            wr_r       <= push ? ptr_inc(wr_r) : wr_r;
            rd_r       <= pop ? ptr_inc(rd_r) : rd_r;
            cnt_r      <= cnt_nxt;
            nmea_ready <= cnt_nxt != 8'(BUF_DEPTH);
        end
    end

    // I2C slave, read direction only; sda only moves while scl is low
    gnsshc_i2_t i2_r, i2_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [3:0] bc_r, bc_nxt;
    logic [6:0] addr_r;
    logic       oe_nxt;
    wire        addr_hit = (sh_r[7:1] == addr_r) && sh_r[0];

    always_comb begin
        i2_nxt = i2_r;
        sh_nxt = sh_r;
        bc_nxt = bc_r;
        oe_nxt = sda_oe;
        pk_nxt = pk_r;
        pop    = 1'b0;
        if (i2_start) begin
            i2_nxt = I2_ADDR;
            bc_nxt = 4'h0;
            oe_nxt = 1'b0;
            pk_nxt = 8'h0;
        end else if (i2_stop) begin
            i2_nxt = I2_IDLE;
            oe_nxt = 1'b0;
        end else begin
            case (i2_r)
                I2_ADDR: begin
                    if (scl_rise) begin
                        sh_nxt = {sh_r[6:0], sda_s_r};
                        bc_nxt = bc_r + 4'h1;
                    end else if (scl_fall && bc_r == 4'h8) begin
                        oe_nxt = addr_hit;
                        i2_nxt = addr_hit ? I2_AACK : I2_IGN;
                    end
                end
                I2_AACK, I2_RNXT: begin
                    if (scl_fall) begin
                        sh_nxt = tx_byte;
                        oe_nxt = ~tx_byte[7];
                        bc_nxt = 4'h1;
                        pop    = have;
                        pk_nxt = have ? pk_r + 8'h1 : pk_r;
                        i2_nxt = I2_TX;
                    end
                end
                I2_TX: begin
                    if (scl_fall && bc_r == 4'h8) begin
                        oe_nxt = 1'b0;
                        i2_nxt = I2_RACK;
                    end else if (scl_fall) begin
                        sh_nxt = {sh_r[6:0], 1'b0};
                        oe_nxt = ~sh_r[6];
                        bc_nxt = bc_r + 4'h1;
                    end
                end
                I2_RACK: begin
                    if (scl_rise) begin
                        i2_nxt = sda_s_r ? I2_IGN : I2_RNXT;
                    end
                end
                default: i2_nxt = i2_r;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            i2_r    <= I2_IDLE;
            sh_r    <= 8'h0;
            bc_r    <= 4'h0;
            pk_r    <= 8'h0;
            sda_oe  <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            i2_r    <= i2_nxt;
            sh_r    <= sh_nxt;
            bc_r    <= bc_nxt;
            pk_r    <= pk_nxt;
            sda_oe  <= oe_nxt;
            sda_out <= 1'b0;
        end
    end

    // APB slave, one wait state
    wire        acc    = psel & penable & pready;
    wire        h_ctrl = (paddr == ADDR_CTRL);
    wire        h_w    = (paddr == ADDR_PPS_W);
    wire        h_p    = (paddr == ADDR_PPS_P);
    wire        h_st   = (paddr == ADDR_STATUS);
    wire        mapped = h_ctrl | h_w | h_p | h_st;
    wire [31:0] status = {8'h0, cnt_r, 5'h0, sbas_en, gnss_mask,
                          pps_en_r, wakeup, pw_r};
    wire [31:0] rd_mux = h_ctrl ? {23'h0, pol_r, 1'b0, addr_r} :
                         h_w    ? ppsw_r :
                         h_p    ? ppsp_r :
                         h_st   ? status : 32'h0;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
            addr_r  <= I2C_ADDR_RST;
            pol_r   <= 1'b0;
            ppsw_r  <= PPS_W_CYC;
            ppsp_r  <= PPS_CY;
        end else begin
            pready  <= psel & penable & ~pready;
            prdata  <= rd_mux;
            pslverr <= ~mapped;
            if (acc && pwrite && h_ctrl) begin
                addr_r <= pwdata[6:0];
                pol_r  <= pwdata[CTRL_POL];
            end
            if (acc && pwrite && h_w) begin
                ppsw_r <= pwdata;
            end
            if (acc && pwrite && h_p) begin
                ppsp_r <= pwdata;
            end
        end
    end

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence seq_bk_exit;
        pw_r == PW_BACKUP && frc_fall && long_hold;
    endsequence
    sequence seq_stop_wake;
        (pw_r == PW_STOP || pw_r == PW_SLEEP) && rx_byte;
    endsequence

    chk_sda_scl_low: assert property (
        $changed(sda_oe) |-> !scl_d_r) else $error("sda moved, scl high");
    chk_addr_ack: assert property (
        i2_r == I2_ADDR && scl_fall && bc_r == 4'h8 && addr_hit
        |=> sda_oe && i2_r == I2_AACK) else $error("no address ack");
    chk_buf_full: assert property (
        cnt_r == 8'(BUF_DEPTH) |-> !nmea_ready) else $error("full, ready");
    chk_backup_exit: assert property (
        seq_bk_exit |=> pw_r == PW_FULL ##1 wakeup)
        else $error("backup exit failed");
    chk_period_exit: assert property (
        pw_r == PW_PERIOD && frc_s_r && pm0 |=> pw_r == PW_FULL)
        else $error("periodic exit failed");
    chk_no_backup: assert property (
        pw_r == PW_FULL && frc_s_r && pm4 |=> pw_r == PW_STOP)
        else $error("mode 4 with hold high");
    chk_stop_wake: assert property (
        seq_stop_wake |=> pw_r == PW_FULL) else $error("rx wake failed");
    chk_pps_enable: assert property (
        c_pe |=> pps_en_r == $past(p0[0])) else $error("pulse enable");
    chk_pps_idle: assert property (
        !pps_run |=> second_pulse_output == $past(pol_r))
        else $error("pps idle");
    chk_wake_low: assert property (
        pw_r == PW_STOP |=> !wakeup) else $error("wakeup high in standby");
    chk_period_off: assert property (
        pw_r == PW_PERIOD && !awake_r |=> !wakeup) else $error("off high");
    chk_restart: assert property (
        c_cold |=> action.cold ##1 !action.cold) else $error("cold start");
    chk_ignore: assert property (
        cmd_valid && pw_r == PW_FULL && !(pm1 || pm4 || c_stby || c_cs)
        |=> $stable(pw_r) && $stable(gnss_mask)) else $error("state moved");

endmodule

// ==== logic/gnsshc_pkg.sv ====
// Purpose: Shared constants and types of the receiver host control block
// Assumes: 200 MHz core clock
// Notes:   Offsets are APB byte addresses

package gnsshc_pkg;

    localparam longint CLK_HZ     = 200_000_000;
    localparam longint HOLD_S     = 1;
    localparam longint PER_ON_S   = 3;
    localparam longint PER_OFF_S  = 15;
    localparam longint PPS_W_US   = 100;
    localparam longint PPS_P_S    = 1;
    localparam longint HOLD_CYC   = HOLD_S * CLK_HZ;
    localparam longint PER_ON_CY  = PER_ON_S * CLK_HZ;
    localparam longint PER_OFF_CY = PER_OFF_S * CLK_HZ;
    localparam longint PPS_P_CYC  = PPS_P_S * CLK_HZ;
    localparam logic [31:0] PPS_W_CYC = 32'(PPS_W_US * CLK_HZ / 1_000_000);

    localparam logic [6:0] I2C_ADDR_RST = 7'h10;
    localparam int         BUF_DEPTH    = 255;
    localparam logic [7:0] PKT_MAX      = 8'hff;
    localparam logic [7:0] FILL_BYTE    = 8'hff;

    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_PPS_W  = 12'h004;
    localparam logic [11:0] ADDR_PPS_P  = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00c;
    localparam int          CTRL_POL    = 8;
    localparam int          ST_WAKE     = 5;
    localparam int          ST_PPS      = 6;
    localparam int          ST_MASK     = 7;
    localparam int          ST_SBAS     = 10;
    localparam int          ST_CNT      = 16;
    localparam logic [2:0]  MASK_RST    = 3'h3;

    localparam logic [9:0] CMD_LINK_TEST  = 10'h000;
    localparam logic [9:0] CMD_HOT        = 10'h065;
    localparam logic [9:0] CMD_WARM       = 10'h066;
    localparam logic [9:0] CMD_COLD       = 10'h067;
    localparam logic [9:0] CMD_FULL_RST   = 10'h068;
    localparam logic [9:0] CMD_ERASE_AID  = 10'h078;
    localparam logic [9:0] CMD_ERASE_ORB  = 10'h07f;
    localparam logic [9:0] CMD_STANDBY    = 10'h0a1;
    localparam logic [9:0] CMD_POWER_MODE = 10'h0e1;
    localparam logic [9:0] CMD_PULSE_EN   = 10'h0ff;
    localparam logic [9:0] CMD_AUGMENT    = 10'h139;
    localparam logic [9:0] CMD_CONST_SEL  = 10'h161;
    localparam logic [3:0] PM_FULL        = 4'h0;
    localparam logic [3:0] PM_PERIODIC    = 4'h1;
    localparam logic [3:0] PM_BACKUP      = 4'h4;

    typedef enum logic [4:0] {
        PW_FULL   = 5'h01,
        PW_BACKUP = 5'h02,
        PW_PERIOD = 5'h04,
        PW_STOP   = 5'h08,
        PW_SLEEP  = 5'h10
    } gnsshc_pw_t;

    typedef enum logic [6:0] {
        I2_IDLE = 7'h01,
        I2_ADDR = 7'h02,
        I2_AACK = 7'h04,
        I2_TX   = 7'h08,
        I2_RACK = 7'h10,
        I2_RNXT = 7'h20,
        I2_IGN  = 7'h40
    } gnsshc_i2_t;

    typedef struct packed {
        logic [9:0]      id;
        logic [2:0]      nparm;
        logic [4:0][3:0] parm;
    } gnsshc_cmd_t;

    typedef struct packed {
        logic hot;
        logic warm;
        logic cold;
        logic full_rst;
        logic erase_aid;
        logic erase_orb;
        logic cfg_save;
    } gnsshc_act_t;

endpackage

// ==== sim/gnsshc_i2c_host.sv ====
// Purpose: I2C host master model that reads sentence packets
// Assumes: Core clock 5 ns, link clock 160 ns
// Notes:   Open drain; the wire has a pull-up
`timescale 1ns/100ps

module gnsshc_i2c_host #(
    parameter int HP = 16
) (
    // Core clock
    input  wire logic clock,
    // Wire
    input  wire logic sda,
    output logic      scl,
    output logic      sda_dn
);
    // Clock stands high between frames
    initial begin
        scl    = 1'b1;
        sda_dn = 1'b0;
    end

    task automatic hw();
        repeat (HP) @(posedge clock);
    endtask

    // Master makes every link clock edge
    task automatic bit_x(input logic v, output logic s);
        sda_dn <= ~v;
        hw();
        scl <= 1'b1;
        hw();
        s = sda;
        scl <= 1'b0;
    endtask

    // Start, address with read, n bytes, nack on last, stop
    task automatic rd(input logic [6:0] a, input int n,
                      output logic ak, output logic [7:0] q[8]);
        logic s;
        sda_dn <= 1'b1;
        hw();
        scl <= 1'b0;
        hw();
        for (int i = 0; i < 8; i++) begin
            bit_x(i < 7 ? a[6-i] : 1'b1, s);
        end
        bit_x(1'b1, ak);
        for (int j = 0; j < n; j++) begin
            for (int i = 7; i >= 0; i--) begin
                bit_x(1'b1, q[j][i]);
            end
            bit_x(j == n - 1, s);
        end
        sda_dn <= 1'b1;
        hw();
        scl <= 1'b1;
        hw();
        sda_dn <= 1'b0;
        // Gap between packets, shortened to keep the run brief
        repeat (4 * HP) @(posedge clock);
    endtask
endmodule

// ==== sim/gnsshc_tb_top.sv ====
// Purpose: Self-checking bench of the receiver host control block
// Assumes: Shortened hold, period and pulse counts
// Notes:   Commands enter already parsed
`timescale 1ns/100ps
`define CHK(a, e) begin \
    total_checks++; \
    if ((a) !== (e)) begin \
        n_mismatch++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); \
    end \
end

module gnsshc_tb_top;
    import gnsshc_pkg::*;
    logic        clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic        pready, pslverr, er, scl, sda, sda_out, sda_oe, sda_dn;
    logic        nmea_valid = 0, nmea_ready, cmd_valid = 0, rx_byte = 0;
    logic [7:0]  nmea_data = 0, q[8];
    gnsshc_cmd_t cmd = '0;
    gnsshc_act_t action;
    logic        force_on = 0, wakeup, spo, echo_valid, sbas_en, ak;
    logic [2:0]  gnss_mask;
    int          n_mismatch = 0, total_checks = 0, c;

    always #2.5 clock = ~clock;
    assign sda = ~(sda_dn | sda_oe);

    gnsshc_top #(.HOLD_CY(200), .ON_CY(50), .OFF_CY(80), .PPS_CY(100)) uut (
        .clock(clock), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .scl(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .nmea_valid(nmea_valid), .nmea_data(nmea_data),
        .nmea_ready(nmea_ready), .cmd_valid(cmd_valid), .cmd(cmd),
        .rx_byte(rx_byte), .force_on(force_on), .wakeup(wakeup),
        .second_pulse_output(spo), .echo_valid(echo_valid),
        .action(action), .gnss_mask(gnss_mask), .sbas_en(sbas_en));
    gnsshc_i2c_host m (.clock(clock), .sda(sda), .scl(scl),
                       .sda_dn(sda_dn));

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clock);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 50);
        r = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        if (k >= 50) begin
            n_mismatch++;
            print_verdict();
        end
    endtask

    task automatic sc(input logic [9:0] i, input logic [2:0] n,
                      input logic [19:0] p);
        @(posedge clock);
        cmd_valid <= 1;
        cmd <= {i, n, p};
        @(posedge clock);
        cmd_valid <= 0;
        #1;
    endtask

    task automatic ww(input logic v);
        int k;
        k = 0;
        while (wakeup !== v && k < 600) begin
            @(posedge clock);
            k++;
        end
        `CHK(wakeup, v)
        if (k >= 600) print_verdict();
    endtask

    task automatic cnt();
        c = 0;
        // Skip the sample launched with the old polarity
        @(posedge clock);
        repeat (100) begin
            @(posedge clock);
            c += spo;
        end
    endtask

    task automatic t_regs();
        `CHK({wakeup, gnss_mask}, 4'hb)
        apb(0, ADDR_CTRL, 0);
        `CHK(r[8:0], 9'h010)
        apb(0, 12'h010, 0);
        `CHK({er, r}, 33'h1_0000_0000)
    endtask

    task automatic t_cmds();
        logic [9:0] ids[6] = '{101, 102, 103, 104, 120, 127};
        for (int i = 0; i < 6; i++) begin
            sc(ids[i], 0, 0);
            `CHK(action, 7'(7'h40 >> i))
        end
        sc(CMD_LINK_TEST, 0, 0);
        `CHK(echo_valid, 1'b1)
        sc(10'h0fb, 1, 1);
        `CHK({echo_valid, action}, 8'h00)
    endtask

    task automatic t_const();
        sc(CMD_CONST_SEL, 5, 20'h10001);
        `CHK(gnss_mask, 3'b101)
        sc(CMD_CONST_SEL, 5, 20'h00100);
        `CHK(gnss_mask, 3'b101)
        sc(CMD_CONST_SEL, 5, 20'h00010);
        `CHK(gnss_mask, 3'b010)
        sc(CMD_AUGMENT, 1, 1);
        `CHK({sbas_en, action}, 8'h81)
    endtask

    task automatic t_i2c();
        for (int i = 0; i < 3; i++) begin
            @(posedge clock);
            nmea_valid <= 1;
            nmea_data <= 8'h24 + 8'(i);
        end
        @(posedge clock);
        nmea_valid <= 0;
        apb(0, ADDR_STATUS, 0);
        `CHK(r[23:16], 8'h03)
        m.rd(7'h10, 5, ak, q);
        `CHK(ak, 1'b0)
        for (int i = 0; i < 5; i++) begin
            `CHK(q[i], i < 3 ? 8'h24 + 8'(i) : 8'hff)
        end
        `CHK({nmea_ready, sda_out}, 2'b10)
        // Batch drained: rest longer before polling again
        repeat (128) @(posedge clock);
        m.rd(7'h11, 1, ak, q);
        `CHK(ak, 1'b1)
    endtask

    task automatic t_pulse();
        apb(1, ADDR_PPS_W, 10);
        sc(CMD_PULSE_EN, 1, 1);
        cnt();
        `CHK(c, 10)
        apb(1, ADDR_CTRL, 32'h110);
        cnt();
        `CHK(c, 90)
        apb(1, ADDR_CTRL, 32'h010);
        sc(CMD_PULSE_EN, 1, 0);
        repeat (4) @(posedge clock);
        cnt();
        `CHK(c, 0)
    endtask

    task automatic t_power();
        force_on <= 1;
        // Hold pin passes two flops before the decode sees it
        repeat (5) @(posedge clock);
        sc(CMD_POWER_MODE, 1, PM_BACKUP);
        ww(0);
        apb(0, ADDR_STATUS, 0);
        `CHK(r[4:0], 5'h08)
        force_on <= 0;
        repeat (250) @(posedge clock);
        force_on <= 1;
        ww(1);
        for (int i = 0; i < 2; i++) begin
            sc(CMD_STANDBY, 1, 20'(i));
            ww(0);
            apb(0, ADDR_STATUS, 0);
            `CHK(r[4:0], 5'(8 << i))
            rx_byte <= 1;
            @(posedge clock);
            rx_byte <= 0;
            ww(1);
        end
        force_on <= 0;
        repeat (5) @(posedge clock);
        sc(CMD_POWER_MODE, 1, PM_BACKUP);
        ww(0);
        apb(0, ADDR_STATUS, 0);
        `CHK(r[4:0], 5'h02)
        force_on <= 1;
        repeat (250) @(posedge clock);
        force_on <= 0;
        ww(1);
        sc(CMD_POWER_MODE, 1, PM_PERIODIC);
        ww(0);
        ww(1);
        force_on <= 1;
        repeat (5) @(posedge clock);
        sc(CMD_POWER_MODE, 1, PM_FULL);
        apb(0, ADDR_STATUS, 0);
        `CHK(r[4:0], 5'h01)
        force_on <= 0;
    endtask

    initial begin
        repeat (2) @(posedge clock);
        rst <= 0;
        @(posedge clock);
        #1;
        t_regs();
        t_cmds();
        t_const();
        t_i2c();
        t_pulse();
        t_power();
        print_verdict();
    end
endmodule
